// file: common/sbt_pkg.sv
// constants, field layouts and state codes of the boundary-scan test port
// assumes a single 100 MHz system clock and an avalon-mm register slave
package sbt_pkg;

  // ************************************************************
  // scan register sizes and special cells
  // ************************************************************
  localparam int BSR_LEN  = 107;
  localparam int IR_LEN   = 3;
  localparam int ID_LEN   = 32;
  localparam int TRI_CELL = 47;   // read-bus tristate control cell

  // ************************************************************
  // instruction codes
  // ************************************************************
  localparam logic [2:0] IR_EXTEST   = 3'h0;
  localparam logic [2:0] IR_IDCODE   = 3'h1;
  localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] IR_SAMPLE   = 3'h4;
  localparam logic [2:0] IR_BYPASS   = 3'h7;
  localparam logic [2:0] IR_CAPTURE  = 3'h1;  // low two bits read 01

  // arbitrary identification value, bit 0 marks an id register present
  localparam logic [31:0] ID_DEFAULT = 32'h0A5C_3E71;

  // ************************************************************
  // register map, byte addresses on 32-bit words
  // ************************************************************
  localparam int           ADDR_W      = 4;
  localparam logic [3:0]   REG_CTRL    = 4'h0;
  localparam logic [3:0]   REG_STATUS  = 4'h4;
  localparam int           CTRL_EN_BIT = 0;
  localparam logic         CTRL_EN_RST = 1'h1;
  localparam int           ST_STATE_LSB = 0;   // tap state, 4 bits
  localparam int           ST_IR_LSB    = 4;   // active instruction, 3 bits
  localparam int           ST_TDOOE_BIT = 8;
  localparam int           ST_RDOE_BIT  = 9;

  // ************************************************************
  // synchroniser reset values: tck low, tms high, tdi high
  // ************************************************************
  localparam logic [2:0] PIN_RST = 3'h6;  // {tdi, tms, tck}

  // ************************************************************
  // tap controller states
  // ************************************************************
  typedef enum logic [3:0] {
    ST_TLR    = 4'b0000,
    ST_RTI    = 4'b0001,
    ST_SEL_DR = 4'b0010,
    ST_CAP_DR = 4'b0011,
    ST_SH_DR  = 4'b0100,
    ST_EX1_DR = 4'b0101,
    ST_PA_DR  = 4'b0110,
    ST_EX2_DR = 4'b0111,
    ST_UPD_DR = 4'b1000,
    ST_SEL_IR = 4'b1001,
    ST_CAP_IR = 4'b1010,
    ST_SH_IR  = 4'b1011,
    ST_EX1_IR = 4'b1100,
    ST_PA_IR  = 4'b1101,
    ST_EX2_IR = 4'b1110,
    ST_UPD_IR = 4'b1111
  } sbt_state_e;

endpackage

// file: hw/sbt_sync3.sv
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes inputs change slowly against clk; output follows stage 2 and 3
`timescale 1ns/1ps
`default_nettype none
module sbt_sync3 #(
  parameter int         W       = 3,
  parameter logic [2:0] RST_VAL = 3'h0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } sbt_sync_s;

  sbt_sync_s q;
  sbt_sync_s d;

  // ************************************************************
  // next state: a bit changes once stages 2 and 3 agree
  // ************************************************************
  always_comb
  begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (q.s2[i] == q.s3[i])
        d.val[i] = q.s3[i];
    end
    if (!rst_n)
    begin
      d.s1  = RST_VAL[W-1:0];
      d.s2  = RST_VAL[W-1:0];
      d.s3  = RST_VAL[W-1:0];
      d.val = RST_VAL[W-1:0];
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    q <= d;
  end

  assign dout = q.val;

endmodule
`default_nettype wire

// file: hw/sbt_tap.sv
// boundary-scan test access port of a synchronous sram
// assumes tck, tms and tdi are asynchronous pins sampled by clk, with tck
// far slower than clk; pin_ring_i comes from core logic on clk
`timescale 1ns/1ps
`default_nettype none

module sbt_tap #(
  parameter logic [31:0] ID_CODE = sbt_pkg::ID_DEFAULT  // arbitrary value
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic [sbt_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          tck,
  input  wire logic                          tms,
  input  wire logic                          tdi,
  output logic                               tdo_o,
  output logic                               tdo_oe,
  input  wire logic [sbt_pkg::BSR_LEN-1:0]   pin_ring_i,
  output logic      [sbt_pkg::BSR_LEN-1:0]   bsr_out_o,
  output logic                               ext_drive_o,
  output logic                               rd_bus_oe_o
);

  typedef struct packed {
    sbt_pkg::sbt_state_e           ts;
    logic [sbt_pkg::IR_LEN-1:0]    ir_sh;
    logic [sbt_pkg::IR_LEN-1:0]    ir;
    logic                          byp;
    logic [sbt_pkg::ID_LEN-1:0]    id_sh;
    logic [sbt_pkg::BSR_LEN-1:0]   bsr_sh;
    logic [sbt_pkg::BSR_LEN-1:0]   bsr_upd;
    logic                          tck_prev;
    logic                          tdo;
    logic                          tdo_oe;
    logic                          ext_drive;
    logic                          rd_oe;
    logic                          ctrl_en;
    logic                          wait_q;
    logic [31:0]                   rdata;
  } sbt_tap_s;

  sbt_tap_s   q;
  sbt_tap_s   d;
  logic [2:0] pins_s;
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  sbt_sync3 #(
    .W       (3),
    .RST_VAL (sbt_pkg::PIN_RST)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({tdi, tms, tck}),
    .dout  (pins_s)
  );

  assign tck_s = pins_s[0];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[2];

  // ************************************************************
  // controller transitions
  // ************************************************************
  function automatic sbt_pkg::sbt_state_e next_state(
    input sbt_pkg::sbt_state_e s,
    input logic                m
  );
    case (s)
      sbt_pkg::ST_TLR:    next_state = m ? sbt_pkg::ST_TLR    : sbt_pkg::ST_RTI;
      sbt_pkg::ST_RTI:    next_state = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
      sbt_pkg::ST_SEL_DR: next_state = m ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
      sbt_pkg::ST_CAP_DR: next_state = m ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_SH_DR:  next_state = m ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_EX1_DR: next_state = m ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PA_DR;
      sbt_pkg::ST_PA_DR:  next_state = m ? sbt_pkg::ST_EX2_DR : sbt_pkg::ST_PA_DR;
      sbt_pkg::ST_EX2_DR: next_state = m ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_UPD_DR: next_state = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
      sbt_pkg::ST_SEL_IR: next_state = m ? sbt_pkg::ST_TLR    : sbt_pkg::ST_CAP_IR;
      sbt_pkg::ST_CAP_IR: next_state = m ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_SH_IR:  next_state = m ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_EX1_IR: next_state = m ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PA_IR;
      sbt_pkg::ST_PA_IR:  next_state = m ? sbt_pkg::ST_EX2_IR : sbt_pkg::ST_PA_IR;
      sbt_pkg::ST_EX2_IR: next_state = m ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_UPD_IR: next_state = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
      default:            next_state = sbt_pkg::ST_TLR;
    endcase
  endfunction

  // ************************************************************
  // data register selection by active instruction
  // ************************************************************
  logic sel_byp;
  logic sel_id;
  logic ring_cap;
  logic pre_load;
  logic dr_lsb;

  // decode the active instruction; reserved codes fall back to bypass
  always_comb
  begin
    sel_id   = 1'b0;
    sel_byp  = 1'b0;
    ring_cap = 1'b0;
    pre_load = 1'b0;
    case (q.ir)
      sbt_pkg::IR_IDCODE:
        sel_id = 1'b1;
      sbt_pkg::IR_BYPASS:
        sel_byp = 1'b1;
      sbt_pkg::IR_SAMPLE_Z:
        ring_cap = 1'b1;
      sbt_pkg::IR_EXTEST,
      sbt_pkg::IR_SAMPLE:
      begin
        ring_cap = 1'b1;
        pre_load = 1'b1;
      end
      default:
        sel_byp = 1'b1;
    endcase
    if (sel_byp)
      dr_lsb = q.byp;
    else if (sel_id)
      dr_lsb = q.id_sh[0];
    else
      dr_lsb = q.bsr_sh[0];
  end

  // ************************************************************
  // next state of the whole port
  // ************************************************************
  logic tck_rise;
  logic tck_fall;

  always_comb
  begin
    d          = q;
    tck_rise   = tck_s & ~q.tck_prev;
    tck_fall   = ~tck_s & q.tck_prev;
    d.tck_prev = tck_s;

    // rising tck: sample tms and tdi, act in current state
    if (tck_rise && q.ctrl_en)
    begin
      case (q.ts)
        sbt_pkg::ST_CAP_IR: d.ir_sh = sbt_pkg::IR_CAPTURE;
        sbt_pkg::ST_SH_IR:  d.ir_sh = {tdi_s, q.ir_sh[2:1]};
        sbt_pkg::ST_UPD_IR: d.ir    = q.ir_sh;
        sbt_pkg::ST_CAP_DR:
        begin
          if (sel_byp)
            d.byp = 1'b0;
          else if (sel_id)
            d.id_sh = ID_CODE;
          else if (ring_cap)
            d.bsr_sh = pin_ring_i;
        end
        sbt_pkg::ST_SH_DR:
        begin
          // captured bits leave while preload bits enter
          if (sel_byp)
            d.byp = tdi_s;
          else if (sel_id)
            d.id_sh = {tdi_s, q.id_sh[sbt_pkg::ID_LEN-1:1]};
          else
            d.bsr_sh = {tdi_s, q.bsr_sh[sbt_pkg::BSR_LEN-1:1]};
        end
        sbt_pkg::ST_UPD_DR:
        begin
          if (pre_load)
            d.bsr_upd = q.bsr_sh;
        end
        default:
        begin
          d.ts = d.ts;
        end
      endcase
      d.ts = next_state(q.ts, tms_s);
    end

    // test-logic-reset forces idcode and enables the read bus
    if (d.ts == sbt_pkg::ST_TLR)
    begin
      d.ir                     = sbt_pkg::IR_IDCODE;
      d.bsr_upd[sbt_pkg::TRI_CELL] = 1'b1;
    end

    // falling tck: present the selected lsb during shifts
    if (tck_fall)
    begin
      if (q.ts == sbt_pkg::ST_SH_IR)
      begin
        d.tdo    = q.ir_sh[0];
        d.tdo_oe = 1'b1;
      end
      else if (q.ts == sbt_pkg::ST_SH_DR)
      begin
        d.tdo    = dr_lsb;
        d.tdo_oe = 1'b1;
      end
      else
        d.tdo_oe = 1'b0;
    end

    // pin-side controls follow the active instruction
    d.ext_drive = (d.ir == sbt_pkg::IR_EXTEST);
    if (d.ir == sbt_pkg::IR_EXTEST)
      d.rd_oe = d.bsr_upd[sbt_pkg::TRI_CELL];
    else if (d.ir == sbt_pkg::IR_SAMPLE_Z)
      d.rd_oe = 1'b0;
    else
      d.rd_oe = 1'b1;

    // avalon slave: answer one cycle after the request
    if (!q.wait_q)
    begin
      d.wait_q = 1'b1;
      if (avs_write && (avs_address == sbt_pkg::REG_CTRL))
        d.ctrl_en = avs_writedata[sbt_pkg::CTRL_EN_BIT];
    end
    else if (avs_read || avs_write)
    begin
      d.wait_q = 1'b0;
      d.rdata  = 32'h0000_0000;
      if (avs_read && (avs_address == sbt_pkg::REG_CTRL))
        d.rdata[sbt_pkg::CTRL_EN_BIT] = q.ctrl_en;
      else if (avs_read && (avs_address == sbt_pkg::REG_STATUS))
      begin
        d.rdata[sbt_pkg::ST_STATE_LSB +: 4] = q.ts;
        d.rdata[sbt_pkg::ST_IR_LSB +: 3]    = q.ir;
        d.rdata[sbt_pkg::ST_TDOOE_BIT]      = q.tdo_oe;
        d.rdata[sbt_pkg::ST_RDOE_BIT]       = q.rd_oe;
      end
    end

    // synchronous reset doubles as power-up
    if (!rst_n)
    begin
      d                            = '0;
      d.ts                         = sbt_pkg::ST_TLR;
      d.ir                         = sbt_pkg::IR_IDCODE;
      d.bsr_upd[sbt_pkg::TRI_CELL] = 1'b1;
      d.rd_oe                      = 1'b1;
      d.ctrl_en                    = sbt_pkg::CTRL_EN_RST;
      d.wait_q                     = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    q <= d;
  end

  // ************************************************************
  // outputs straight from the state register
  // ************************************************************
  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = q.wait_q;
  assign tdo_o           = q.tdo;
  assign tdo_oe          = q.tdo_oe;
  assign bsr_out_o       = q.bsr_upd;
  assign ext_drive_o     = q.ext_drive;
  assign rd_bus_oe_o     = q.rd_oe;

endmodule
`default_nettype wire

// file: bench/sbt_tap_asserts.sv
// checker for the test port's bus handshake and pin timing
// assumes tck half periods of at least 6 clk, one clk domain
`timescale 1ns/1ps
`default_nettype none
module sbt_tap_chk (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic [sbt_pkg::ADDR_W-1:0]  avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [31:0]                 avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic                        tck,
  input wire logic                        tdo_o,
  input wire logic                        tdo_oe,
  input wire logic [sbt_pkg::BSR_LEN-1:0] bsr_out_o,
  input wire logic                        ext_drive_o,
  input wire logic                        rd_bus_oe_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // bus handshake
  // ****************
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_answer: assert property (s_req |=> s_ans)
    else $error("request not answered after one cycle");
  chk_no_spurious: assert property (
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address != sbt_pkg::REG_CTRL && avs_address != sbt_pkg::REG_STATUS
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // ****************
  // pin edge timing
  // ****************
  chk_tdo_on_fall: assert property ($changed(tdo_o) |-> !tck)
    else $error("tdo moved while tck high");
  chk_oe_on_fall: assert property ($changed(tdo_oe) |-> !tck)
    else $error("tdo enable moved while tck high");
  chk_latch_on_rise: assert property ($changed(bsr_out_o) |-> tck)
    else $error("cell latch moved while tck low");
  chk_ir_on_rise: assert property ($changed(ext_drive_o) |-> tck)
    else $error("instruction moved while tck low");
  chk_tristate_cell: assert property (ext_drive_o |->
    rd_bus_oe_o == bsr_out_o[sbt_pkg::TRI_CELL])
    else $error("read bus enable not following cell");
endmodule
bind sbt_tap sbt_tap_chk u_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tck(tck), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .bsr_out_o(bsr_out_o),
  .ext_drive_o(ext_drive_o), .rd_bus_oe_o(rd_bus_oe_o)
);
`default_nettype wire

// file: bench/sbt_jtag_host.sv
// board-side scan controller model driving tck, tms and tdi
// assumes the clk of the port under test; tck half period is 8 clk
`timescale 1ns/1ps
`default_nettype none
module sbt_jtag_host (
  input  wire logic clk,
  input  wire logic tdo_o,
  input  wire logic tdo_oe,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi
);
  // idle: tck parked low, tms and tdi at pull-up level
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one tck period, tdo read just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge clk);
    q = tdo_oe ? tdo_o : 1'bz;
    tck <= 1'b1;
    repeat (8) @(posedge clk);
    tck <= 1'b0;
  endtask
  // five tms-high clocks, then to idle
  task automatic tap_reset;
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
  // select, capture, shift n bits lsb first, update, idle
  task automatic shift(input logic ir, input int n,
                       input logic [127:0] din, output logic [127:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule
`default_nettype wire

// file: bench/test_sbt_tap.sv
// self-checking bench for the boundary-scan test port
// assumes the controller model and the bound checker beside it
`timescale 1ns/1ps
`default_nettype none
module test_sbt_tap;
  logic         clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0]   avs_address;
  logic [31:0]  avs_writedata, avs_readdata, d;
  logic         tck, tms, tdi, tdo_o, tdo_oe, ext_drive_o, rd_bus_oe_o;
  logic [106:0] pin_ring_i, bsr_out_o;
  logic [127:0] q, p1, p2, p3, p4;
  int           n_errors, checks;
  sbt_tap uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .pin_ring_i(pin_ring_i),
    .bsr_out_o(bsr_out_o), .ext_drive_o(ext_drive_o),
    .rd_bus_oe_o(rd_bus_oe_o));
  sbt_jtag_host host (.clk(clk), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .tck(tck), .tms(tms), .tdi(tdi));
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // compare and count
  task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= wd;
    // only the watchdog ends a hang here
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // verdict and end of run
  task give_verdict;
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #400000;
    n_errors++;
    give_verdict;
  end
  // test sequence
  initial
  begin
    n_errors = 0;
    checks = 0;
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    p1 = {4{32'h9C3A_5E17}};
    p2 = {4{32'h6B2D_4C81}};
    p3 = {4{32'h27F0_8D45}};
    p4 = {4{32'hD1E6_B39A}};
    pin_ring_i = p1[106:0];
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    av(1'b0, sbt_pkg::REG_STATUS, 32'h0, d);
    cmp({d[9], d[6:0]}, {1'b1, sbt_pkg::IR_IDCODE, 4'h0});
    cmp(bsr_out_o, 107'h1 << sbt_pkg::TRI_CELL);
    av(1'b0, sbt_pkg::REG_CTRL, 32'h0, d);
    cmp(d[0], sbt_pkg::CTRL_EN_RST);
    av(1'b1, 4'h8, 32'hFFFF_FFFF, d);
    av(1'b0, 4'h8, 32'h0, d);
    cmp(d, 32'h0);
    av(1'b1, sbt_pkg::REG_CTRL, 32'h0, d);
    host.step(1'b0, 1'b1, q[0]);
    av(1'b0, sbt_pkg::REG_STATUS, 32'h0, d);
    cmp(d[3:0], sbt_pkg::ST_TLR);
    av(1'b1, sbt_pkg::REG_CTRL, 32'h1, d);
    host.step(1'b0, 1'b1, q[0]);
    av(1'b0, sbt_pkg::REG_STATUS, 32'h0, d);
    cmp(d[3:0], sbt_pkg::ST_RTI);
    host.shift(1'b0, 32, 128'h0, q);
    cmp(q[31:0], sbt_pkg::ID_DEFAULT);
    host.shift(1'b1, 3, sbt_pkg::IR_SAMPLE, q);
    cmp(q[1:0], 2'h1);
    av(1'b0, sbt_pkg::REG_STATUS, 32'h0, d);
    cmp(d[6:4], sbt_pkg::IR_SAMPLE);
    host.shift(1'b0, 107, p4, q);
    cmp(q[106:0], p1[106:0]);
    cmp(bsr_out_o, p4[106:0]);
    host.shift(1'b1, 3, sbt_pkg::IR_EXTEST, q);
    cmp({ext_drive_o, rd_bus_oe_o}, 2'h3);
    pin_ring_i <= p3[106:0];
    host.shift(1'b0, 107, p2, q);
    cmp(q[106:0], p3[106:0]);
    cmp({bsr_out_o, rd_bus_oe_o}, {p2[106:0], 1'b0});
    host.shift(1'b1, 3, sbt_pkg::IR_SAMPLE_Z, q);
    cmp({ext_drive_o, rd_bus_oe_o}, 2'h0);
    pin_ring_i <= p1[106:0];
    host.shift(1'b0, 107, p4, q);
    cmp(q[106:0], p1[106:0]);
    cmp({bsr_out_o, rd_bus_oe_o}, {p2[106:0], 1'b0});
    host.shift(1'b1, 3, sbt_pkg::IR_BYPASS, q);
    host.shift(1'b0, 8, 128'hB5, q);
    cmp(q[7:0], 8'h6A);
    cmp({ext_drive_o, rd_bus_oe_o, tdo_oe}, 3'h2);
    host.tap_reset;
    av(1'b0, sbt_pkg::REG_STATUS, 32'h0, d);
    cmp(d[6:4], sbt_pkg::IR_IDCODE);
    cmp(bsr_out_o[sbt_pkg::TRI_CELL], 1'b1);
    give_verdict;
  end
endmodule
`default_nettype wire
